/* src/serial_port_pkg.sv */
package serial_port_pkg;

  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET  = 8'h04;
  localparam logic [7:0] DIVIDER_OFFSET = 8'h08;
  localparam logic [7:0] TX_OFFSET      = 8'h0C;
  localparam logic [7:0] RX_OFFSET      = 8'h10;

  localparam int CTL_ENABLE    = 0;
  localparam int CTL_MASTER    = 1;
  localparam int CTL_PHASE     = 2;
  localparam int CTL_POLARITY  = 3;
  localparam int CTL_LSB_FIRST = 5;
  localparam int CTL_TX_TRIG   = 6;
  localparam int CTL_RESEND    = 7;
  localparam int CTL_OVERWRITE = 8;
  localparam int CTL_CS_ENABLE = 9;
  localparam int CTL_SLAVE_OE  = 10;
  localparam int CTL_LOOPBACK  = 11;
  localparam int CTL_CONTINUE  = 12;

  localparam int STA_TX_EMPTY = 0;
  localparam int STA_TX_IRQ   = 1;
  localparam int STA_TX_UNDER = 2;
  localparam int STA_RX_FULL  = 3;
  localparam int STA_RX_IRQ   = 4;
  localparam int STA_RX_OVER  = 5;

  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] CONTROL_MASK   = 16'h1FEF;
  localparam logic [7:0]  DIVIDER_RESET  = 8'h00;
  localparam logic [8:0]  MIN_HALF       = 9'h004;
  localparam logic [4:0]  LAST_HALF      = 5'h0F;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
  localparam logic [8:0]  STALL_CYCLES   = 9'h008;

  typedef enum logic [2:0] {
    MODE_IDLE  = 3'b001,
    MODE_RUN   = 3'b010,
    MODE_STALL = 3'b100
  } mode_type;

  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic data;
    logic mosi_oe;
    logic miso_oe;
    logic cs_n;
    logic cs_oe;
  } pin_type;

  typedef struct packed {
    logic       write;
    logic [7:0] addr;
  } bus_phase_type;

endpackage

/* src/spi_master_slave_port.sv */
`timescale 1ns/1ns
`default_nettype none

module spi_master_slave_port
  import serial_port_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  input  wire logic        sclk_in,
  output var  logic        sclk_out,
  output var  logic        sclk_oe,
  input  wire logic        mosi_in,
  output var  logic        mosi_out,
  output var  logic        mosi_oe,
  input  wire logic        miso_in,
  output var  logic        miso_out,
  output var  logic        miso_oe,
  input  wire logic        chip_select_n_in,
  output var  logic        chip_select_n_out,
  output var  logic        chip_select_n_oe
);

  typedef struct packed {
    logic [15:0]   control;
    logic [7:0]    divider;
    logic [7:0]    tx_data;
    logic [7:0]    rx_data;
    logic [7:0]    last_tx;
    logic [7:0]    tx_sh;
    logic [7:0]    rx_sh;
    logic          tx_full;
    logic          rx_full;
    logic          tx_under;
    logic          rx_over;
    logic          start_req;
    mode_type      mode;
    logic [8:0]    timer;
    logic [4:0]    halves;
    logic [3:0]    count;
    logic          sclk_s1;
    logic          sclk_s2;
    logic          sclk_s3;
    logic          cs_s1;
    logic          cs_s2;
    logic          cs_s3;
    logic          mosi_s1;
    logic          mosi_s2;
    pin_type       pins;
    bus_phase_type bus;
    logic [31:0]   rdata;
    logic          ready;
    logic          resp;
  } state_type;

  state_type state;
  state_type next_state;

  function automatic logic head(input logic [7:0] sh, input logic lsb);
    head = lsb ? sh[0] : sh[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction

  // slow edge kept at four cycles minimum so a bit never beats core/8
  function automatic logic [8:0] half_period(input logic [7:0] div);
    logic [8:0] h;
    h = {1'b0, div} + 9'h001;
    half_period = (h < MIN_HALF) ? MIN_HALF : h;
  endfunction

  function automatic logic [7:0] status_of(input state_type s);
    logic [7:0] v;
    v = 8'h00;
    v[STA_TX_EMPTY] = ~s.tx_full;
    v[STA_TX_UNDER] = s.tx_under;
    v[STA_TX_IRQ]   = ~s.tx_full | s.tx_under;
    v[STA_RX_FULL]  = s.rx_full;
    v[STA_RX_OVER]  = s.rx_over;
    v[STA_RX_IRQ]   = s.rx_full | s.rx_over;
    status_of = v;
  endfunction

  logic       enabled;
  logic       master;
  logic       cpol;
  logic       cpha;
  logic       lsb;
  logic       edge_now;
  logic       leading;
  logic       sample_edge;
  logic       launch_edge;
  logic       sample_bit;
  logic       do_load;
  logic       addr_ok;
  logic [7:0] load_val;
  logic [7:0] got;
  logic       over_now;
  logic       start_now;

  always_comb begin
    next_state = state;
    enabled  = state.control[CTL_ENABLE];
    master   = state.control[CTL_MASTER];
    cpol     = state.control[CTL_POLARITY];
    cpha     = state.control[CTL_PHASE];
    lsb      = state.control[CTL_LSB_FIRST];
    edge_now = 1'b0;
    leading  = 1'b0;
    do_load  = 1'b0;
    load_val = 8'h00;
    got      = 8'h00;
    over_now = 1'b0;
    start_now = state.control[CTL_TX_TRIG] ? state.tx_full : state.start_req;

    // data phase of a write captured on the previous edge
    if (state.bus.write) begin
      unique case (state.bus.addr)
        CONTROL_OFFSET: next_state.control = hwdata[15:0] & CONTROL_MASK;
        DIVIDER_OFFSET: next_state.divider = hwdata[7:0];
        TX_OFFSET: begin
          next_state.tx_data  = hwdata[7:0];
          next_state.tx_full  = 1'b1;
          next_state.tx_under = 1'b0;
        end
        default: ;
      endcase
    end

    // synchronisers; the second stage is sampled, the third stage of sclk and cs only for edge detection
    next_state.sclk_s1 = sclk_in;
    next_state.sclk_s2 = state.sclk_s1;
    next_state.sclk_s3 = state.sclk_s2;
    next_state.cs_s1   = chip_select_n_in;
    next_state.cs_s2   = state.cs_s1;
    next_state.cs_s3   = state.cs_s2;
    next_state.mosi_s1 = mosi_in;
    next_state.mosi_s2 = state.mosi_s1;

    if (!enabled) begin
      next_state.mode      = MODE_IDLE;
      next_state.pins.cs_n = 1'b1;
      next_state.pins.sclk = cpol;
      next_state.count     = 4'h0;
      next_state.start_req = 1'b0;
    end else if (master) begin
      unique case (state.mode)
        MODE_IDLE: begin
          next_state.pins.sclk = cpol;
          next_state.pins.cs_n = 1'b1;
          if (start_now) begin
            next_state.mode      = MODE_RUN;
            next_state.halves    = 5'h00;
            next_state.timer     = half_period(state.divider) - 9'h001;
            next_state.count     = 4'h0;
            next_state.start_req = 1'b0;
            next_state.pins.cs_n = 1'b0;
            do_load              = 1'b1;
          end
        end
        MODE_RUN: begin
          if (state.timer == 9'h000) begin
            next_state.timer     = half_period(state.divider) - 9'h001;
            next_state.pins.sclk = ~state.pins.sclk;
            edge_now             = 1'b1;
            leading              = ~state.halves[0];
            next_state.halves    = state.halves + 5'h01;
            if (state.halves == LAST_HALF) begin
              next_state.halves = 5'h00;
              next_state.count  = 4'h0;
              if (state.control[CTL_CONTINUE] && state.tx_full) begin
                do_load = 1'b1;
              end else begin
                next_state.pins.cs_n = 1'b1;
                next_state.mode      = state.tx_full ? MODE_STALL : MODE_IDLE;
                next_state.timer     = STALL_CYCLES;
              end
            end
          end else begin
            next_state.timer = state.timer - 9'h001;
          end
        end
        MODE_STALL: begin
          if (state.timer == 9'h000) begin
            next_state.mode = MODE_IDLE;
          end else begin
            next_state.timer = state.timer - 9'h001;
          end
        end
        default: next_state.mode = MODE_IDLE;
      endcase
    end else begin
      next_state.mode      = MODE_IDLE;
      next_state.pins.cs_n = 1'b1;
      next_state.pins.sclk = cpol;
      if (state.cs_s2) begin
        next_state.count = 4'h0;
      end else begin
        if (state.cs_s3) begin
          next_state.count = 4'h0;
          do_load          = 1'b1;
        end
        // polarity and phase come from control, set by software to match
        edge_now = state.sclk_s2 ^ state.sclk_s3;
        leading  = state.sclk_s2 != cpol;
      end
    end

    // loopback feeds the outgoing line straight back into sampling
    if (state.control[CTL_LOOPBACK]) begin
      sample_bit = state.pins.data;
    end else if (master) begin
      sample_bit = miso_in;
    end else begin
      sample_bit = state.mosi_s2;
    end
    sample_edge = edge_now & (leading ^ cpha);
    launch_edge = edge_now & ~(leading ^ cpha);

    if (sample_edge) begin
      next_state.rx_sh = shift_in(state.rx_sh, sample_bit, lsb);
      next_state.count = state.count + 4'h1;
      if (state.count == BITS_PER_BYTE - 4'h1) begin
        got              = shift_in(state.rx_sh, sample_bit, lsb);
        next_state.count = 4'h0;
        if (state.rx_full) begin
          next_state.rx_over = 1'b1;
          over_now           = 1'b1;
        end
        if (!state.rx_full || state.control[CTL_OVERWRITE]) begin
          next_state.rx_data = got;
          next_state.rx_full = 1'b1;
        end
        if (!master) begin
          do_load = 1'b1;
        end
      end
    end

    if (launch_edge) begin
      if (state.count != 4'h0) begin
        next_state.tx_sh     = shift_in(state.tx_sh, 1'b0, lsb);
        next_state.pins.data = head(shift_in(state.tx_sh, 1'b0, lsb), lsb);
      end else begin
        next_state.pins.data = head(state.tx_sh, lsb);
      end
    end

    if (do_load) begin
      if (next_state.tx_full) begin
        load_val           = next_state.tx_data;
        next_state.tx_full = 1'b0;
      end else begin
        if (state.control[CTL_RESEND]) begin
          load_val = state.last_tx;
        end else begin
          load_val = 8'h00;
        end
        next_state.tx_under = 1'b1;
      end
      next_state.last_tx   = load_val;
      next_state.tx_sh     = load_val;
      next_state.pins.data = head(load_val, lsb);
    end

    next_state.pins.sclk_oe = enabled & master;
    next_state.pins.mosi_oe = enabled & master;
    next_state.pins.miso_oe = enabled & ~master & state.control[CTL_SLAVE_OE]
                            & ~state.cs_s2;
    next_state.pins.cs_oe   = enabled & master & state.control[CTL_CS_ENABLE];

    // address phase; read data is taken after this cycle's updates
    addr_ok        = hsel & htrans[1] & hready;
    next_state.bus.write = addr_ok & hwrite;
    next_state.bus.addr  = haddr[7:0];
    next_state.ready     = 1'b1;
    next_state.resp      = 1'b0;
    next_state.rdata     = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        CONTROL_OFFSET: next_state.rdata = {16'h0000, next_state.control};
        STATUS_OFFSET:  next_state.rdata = {24'h000000, status_of(next_state)};
        DIVIDER_OFFSET: next_state.rdata = {24'h000000, next_state.divider};
        RX_OFFSET: begin
          next_state.rdata   = {24'h000000, next_state.rx_data};
          next_state.rx_full = 1'b0;
          next_state.rx_over = over_now; // a fresh overflow outlives the read
          if (enabled && master && !state.control[CTL_TX_TRIG]) begin
            next_state.start_req = 1'b1;
          end
        end
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state           <= '0;
      state.control   <= CONTROL_RESET;
      state.divider   <= DIVIDER_RESET;
      state.mode      <= MODE_IDLE;
      state.sclk_s1   <= 1'b0;
      state.cs_s1     <= 1'b1;
      state.cs_s2     <= 1'b1;
      state.cs_s3     <= 1'b1;
      state.pins.cs_n <= 1'b1;
      state.ready     <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign hreadyout         = state.ready;
  assign hresp             = state.resp;
  assign hrdata            = state.rdata;
  assign sclk_out          = state.pins.sclk;
  assign sclk_oe           = state.pins.sclk_oe;
  assign mosi_out          = state.pins.data;
  assign mosi_oe           = state.pins.mosi_oe;
  assign miso_out          = state.pins.data;
  assign miso_oe           = state.pins.miso_oe;
  assign chip_select_n_out = state.pins.cs_n;
  assign chip_select_n_oe  = state.pins.cs_oe;

endmodule // spi_master_slave_port

`default_nettype wire

/* testbench/spi_master_slave_port_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_master_slave_port_monitor (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        sclk_out,
  input wire logic        sclk_oe,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        chip_select_n_out,
  input wire logic        chip_select_n_oe
);
  logic [5:0] cnt;
  logic       sclk_prev;
  logic [5:0] toggles;
  logic       read_idle;
  // toggles seen while selected; the edge landing with the release is added late
  always_ff @(posedge ref_clk) begin
    sclk_prev <= sclk_out;
    if (!reset_n || chip_select_n_out)
      cnt <= 6'h00;
    else if (sclk_out != sclk_prev)
      cnt <= cnt + 6'h01;
  end
  assign toggles = cnt + {5'h00, sclk_out ^ sclk_prev};
  assign read_idle = hready && !(hsel && htrans[1] && !hwrite);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence cs_release;
    $rose(chip_select_n_out);
  endsequence
  sequence stall_hold;
    chip_select_n_out [*8];
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_RDATA_IDLE: assert property (read_idle |=> hrdata == 32'h00000000)
    else $error("read data not zero outside a read");
  AST_MISO_DIR: assert property (mosi_oe |-> !miso_oe)
    else $error("both data lines driven");
  AST_MOSI_DIR: assert property (mosi_oe == sclk_oe)
    else $error("data out and clock out drive differ");
  AST_CS_OE: assert property (chip_select_n_oe |-> sclk_oe)
    else $error("select driven outside master mode");
  AST_SCLK_HALF: assert property (sclk_oe && $changed(sclk_out) |=> $stable(sclk_out) [*3])
    else $error("serial clock half period under four cycles");
  AST_BYTE_EDGES: assert property (cs_release |-> toggles[3:0] == 4'h0 && toggles != 6'h00)
    else $error("select released inside a byte");
  AST_STALL: assert property (cs_release |=> stall_hold)
    else $error("select reasserted without stall");
endmodule // spi_master_slave_port_monitor
bind spi_master_slave_port spi_master_slave_port_monitor monitor_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .chip_select_n_out(chip_select_n_out), .chip_select_n_oe(chip_select_n_oe));
`default_nettype wire

/* testbench/serial_peer_model.sv */
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model (
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       mosi,
  input wire logic [7:0] send,
  output var logic       miso,
  output var logic [7:0] got
);
  logic [7:0] sh;
  initial begin
    miso = 1'b1;
    got = 8'h00;
    sh = 8'h00;
  end
  // idle-low clock, sample on leading edge only
  always @(negedge cs_n) begin
    sh = send;
    miso = send[7];
  end
  always @(posedge sclk)
    if (!cs_n)
      got = {got[6:0], mosi};
  always @(negedge sclk)
    if (!cs_n) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  // released line keeps no value
  always @(posedge cs_n)
    miso = ~miso;
endmodule // serial_peer_model
`default_nettype wire

/* testbench/tb_spi_master_slave_port.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_spi_master_slave_port;
  import serial_port_pkg::*;
  logic        ref_clk, reset_n, hsel, hwrite, hreadyout;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        sclk_out, mosi_out, miso_in, chip_select_n_out;
  logic        sclk_in, mosi_in, chip_select_n_in, miso_out, miso_oe;
  logic [7:0]  peer_send, peer_got, slave_got;
  int          n_mismatch, checked, edges, falls;
  time         last_rise, per;
  spi_master_slave_port dut (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(), .mosi_in(mosi_in),
    .mosi_out(mosi_out), .mosi_oe(), .miso_in(miso_in), .miso_out(miso_out),
    .miso_oe(miso_oe), .chip_select_n_in(chip_select_n_in),
    .chip_select_n_out(chip_select_n_out), .chip_select_n_oe());
  serial_peer_model peer (.sclk(sclk_out), .cs_n(chip_select_n_out), .mosi(mosi_out),
    .send(peer_send), .miso(miso_in), .got(peer_got));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge sclk_out) begin
    edges++;
    per = $time - last_rise;
    last_rise = $time;
  end
  always @(negedge chip_select_n_out) falls++;
  task automatic close_out(input logic hung);
    if (hung)
      n_mismatch++;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (k >= 64)
      close_out(1'b1);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check(q, exp);
  endtask
  task automatic wait_cs(input logic lvl);
    int k;
    k = 0;
    while (chip_select_n_out !== lvl && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 2000)
      close_out(1'b1);
  endtask
  // second write lands while the first byte shifts, so the transmit side refills
  task automatic xfer(input logic [15:0] ctl, input logic [7:0] tx, input logic [7:0] ps,
                      input logic two);
    edges = 0;
    falls = 0;
    peer_send = ps;
    wr(CONTROL_OFFSET, {16'h0000, ctl});
    wr(TX_OFFSET, {24'h000000, tx});
    wait_cs(1'b0);
    if (two)
      wr(TX_OFFSET, {24'h000000, tx});
    wait_cs(1'b1);
    repeat (12) @(posedge ref_clk);
    wait_cs(1'b1);
    repeat (12) @(posedge ref_clk);
  endtask
  // bit 6 clear: the receive read starts the byte; nothing written, so it underflows
  task automatic read_start(input logic [15:0] ctl, input logic [7:0] ps,
                            input logic [31:0] rx_exp);
    peer_send = ps;
    wr(CONTROL_OFFSET, {16'h0000, ctl});
    rd_chk(RX_OFFSET, rx_exp);
    wait_cs(1'b0);
    wait_cs(1'b1);
    repeat (12) @(posedge ref_clk);
  endtask
  // bench plays the far master, eight core cycles a half bit to cover the sync lag
  task automatic slave_xfer(input logic [7:0] m_send);
    logic [7:0] sh;
    sh = m_send;
    slave_got = 8'h00;
    @(posedge ref_clk);
    chip_select_n_in <= 1'b0;
    mosi_in <= sh[7];
    repeat (8) begin
      repeat (8) @(posedge ref_clk);
      sclk_in <= 1'b1;
      slave_got = {slave_got[6:0], miso_out};
      sh = {sh[6:0], 1'b0};
      repeat (8) @(posedge ref_clk);
      sclk_in <= 1'b0;
      mosi_in <= sh[7];
    end
    check({31'h0, miso_oe}, 32'h00000001);
    repeat (8) @(posedge ref_clk);
    chip_select_n_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check({31'h0, miso_oe}, 32'h00000000);
  endtask
  initial begin
    {reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {sclk_in, mosi_in, chip_select_n_in} = 3'b001;
    {n_mismatch, checked, edges, falls} = '0;
    peer_send = 8'h00;
    last_rise = 0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_chk(CONTROL_OFFSET, 32'h00000000);
    rd_chk(STATUS_OFFSET, 32'h00000003);
    rd_chk(DIVIDER_OFFSET, 32'h00000000);
    wr(CONTROL_OFFSET, 32'hFFFFFFFE);
    rd_chk(CONTROL_OFFSET, 32'h00001FEE);
    wr(STATUS_OFFSET, 32'h000000FF);
    rd_chk(STATUS_OFFSET, 32'h00000003);
    wr(RX_OFFSET, 32'h0000005A);
    rd_chk(RX_OFFSET, 32'h00000000);
    rd_chk(TX_OFFSET, 32'h00000000);
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h00000000);
    wr(DIVIDER_OFFSET, 32'hFFFFFF05);
    rd_chk(DIVIDER_OFFSET, 32'h00000005);
    $display("test registers done");
    xfer(16'h0243, 8'hA5, 8'h3C, 1'b0);
    check({24'h000000, peer_got}, 32'h000000A5);
    check(32'(edges), 32'd8);
    check(32'(per), 32'd240);
    rd_chk(STATUS_OFFSET, 32'h0000001B);
    rd_chk(RX_OFFSET, 32'h0000003C);
    wr(DIVIDER_OFFSET, 32'h00000000);
    xfer(16'h0263, 8'h1E, 8'h0F, 1'b0);
    check({24'h000000, peer_got}, 32'h00000078);
    check(32'(per), 32'd160);
    rd_chk(RX_OFFSET, 32'h000000F0);
    $display("test master transfer done");
    xfer(16'h0243, 8'h11, 8'h22, 1'b0);
    xfer(16'h0243, 8'h33, 8'h44, 1'b0);
    rd_chk(STATUS_OFFSET, 32'h0000003B);
    rd_chk(RX_OFFSET, 32'h00000022);
    xfer(16'h0343, 8'h55, 8'h66, 1'b0);
    xfer(16'h0343, 8'h77, 8'h88, 1'b0);
    rd_chk(RX_OFFSET, 32'h00000088);
    $display("test overflow done");
    xfer(16'h0243, 8'h5A, 8'h00, 1'b1);
    check(32'(falls), 32'd2);
    check(32'(edges), 32'd16);
    xfer(16'h1243, 8'hA5, 8'h00, 1'b1);
    check(32'(falls), 32'd1);
    check(32'(edges), 32'd16);
    check({24'h000000, peer_got}, 32'h000000A5);
    rd_chk(RX_OFFSET, 32'h00000000);
    xfer(16'h0A43, 8'hC3, 8'h00, 1'b0);
    rd_chk(RX_OFFSET, 32'h000000C3);
    $display("test stall continuous loopback done");
    read_start(16'h0283, 8'h5C, 32'h000000C3);
    check({24'h000000, peer_got}, 32'h000000C3);
    rd_chk(STATUS_OFFSET, 32'h0000001F);
    read_start(16'h0203, 8'h00, 32'h0000005C);
    check({24'h000000, peer_got}, 32'h00000000);
    $display("test underflow done");
    wr(CONTROL_OFFSET, 32'h00000401);
    rd_chk(RX_OFFSET, 32'h00000000);
    wr(TX_OFFSET, 32'h00000096);
    slave_xfer(8'h69);
    check({24'h000000, slave_got}, 32'h00000096);
    rd_chk(STATUS_OFFSET, 32'h0000001F);
    rd_chk(RX_OFFSET, 32'h00000069);
    $display("test slave done");
    close_out(1'b0);
  end
endmodule // tb_spi_master_slave_port
`default_nettype wire
